// ===== hw/cpt_channel.sv
`default_nettype none
module cpt_channel
  import cpt_pkg::*;
(
  input  wire logic      aclk,    // System clock
  input  wire logic      aresetn, // Sync reset, low
  input  wire logic      tick,    // Count enable
  input  wire logic [1:0] cclr,   // Clear select
  input  wire cpt_byte_t cora,    // Constant A
  input  wire cpt_byte_t corb,    // Constant B
  input  wire logic      wr_en,   // Software write of counter
  input  wire cpt_byte_t wr_data, // Written value
  output cpt_byte_t      cnt,     // Counter
  output logic           eq_a,    // Counter equals A
  output logic           hit_a,   // First cycle of A match
  output logic           hit_b,   // First cycle of B match
  output logic           evt_a,   // Count edge while A match
  output logic           evt_b    // Count edge while B match
);
  logic eq_b;
  logic eq_a_q_ff;
  logic eq_b_q_ff;

  assign eq_a  = (cnt == cora);
  assign eq_b  = (cnt == corb);
  assign hit_a = eq_a && !eq_a_q_ff;
  assign hit_b = eq_b && !eq_b_q_ff;
  assign evt_a = tick && eq_a;
  assign evt_b = tick && eq_b;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      eq_a_q_ff <= 1'b0;
      eq_b_q_ff <= 1'b0;
    end else begin
      eq_a_q_ff <= eq_a;
      eq_b_q_ff <= eq_b;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 8'h00;
    end else if (wr_en) begin
      cnt <= wr_data;
    end else if (tick) begin
      if ((cclr == 2'h1 && eq_a) || (cclr == 2'h2 && eq_b)) begin
        cnt <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule // cpt_channel
`default_nettype wire

// ===== hw/cpt_defs.svh
`ifndef CPT_DEFS_SVH
`define CPT_DEFS_SVH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define CPT_IDX_CH0_CTRL   24'hFFFFB0
`define CPT_IDX_CH1_CTRL   24'hFFFFB1
`define CPT_IDX_CH0_STAT   24'hFFFFB2
`define CPT_IDX_CH1_STAT   24'hFFFFB3
`define CPT_IDX_PER_CONST  24'hFFFFB4
`define CPT_IDX_PCNT_CONST 24'hFFFFB5
`define CPT_IDX_HALF_CONST 24'hFFFFB6
`define CPT_IDX_CH1_CONB   24'hFFFFB7
`define CPT_IDX_PER_CNT    24'hFFFFB8
`define CPT_IDX_PULSE_CNT  24'hFFFFB9
`define CPT_IDX_CH0_CLK    24'hFFFFBA
`define CPT_IDX_CH1_CLK    24'hFFFFBB
`define CPT_IDX_STOP       24'hFFFDC8
`define CPT_IDX_IRQ_STAT   24'hFFFFC0
`define CPT_IDX_IRQ_MASK   24'hFFFFC1

// ****************************************
// Field positions
// ****************************************
`define CPT_MATCH_A_IRQ_ENABLE_BIT 6
`define CPT_CCLR_HI   4
`define CPT_CCLR_LO   3
`define CPT_CMFB_BIT  7
`define CPT_CMFA_BIT  6
`define CPT_STOP_BIT  8

// ****************************************
// Reset values
// ****************************************
`define CPT_RST_CTRL  8'h00
`define CPT_RST_STAT0 8'h09
`define CPT_RST_CONST 8'hFF
`define CPT_RST_STOP  1'b1
`define CPT_RST_MASK  3'h0

// ****************************************
// Timing
// ****************************************
`define CPT_ACLK_MHZ  200
`define CPT_PCLK_MHZ  16
`define CPT_STEP_NS   500
`define CPT_STEP_PCLK ((`CPT_STEP_NS * `CPT_PCLK_MHZ) / 1000)
`define CPT_MASK_D2    13'h0001
`define CPT_MASK_D8    13'h0007
`define CPT_MASK_D32   13'h001F
`define CPT_MASK_D64   13'h003F
`define CPT_MASK_D1024 13'h03FF
`define CPT_MASK_D8192 13'h1FFF

`endif

// ===== hw/cpt_pkg.sv
`default_nettype none
`include "cpt_defs.svh"
package cpt_pkg;
  typedef logic [7:0] cpt_byte_t;
  typedef enum logic [2:0] {
    CPT_CKS_OFF     = 3'h0,
    CPT_CKS_CASCADE = 3'h4
  } cpt_cks_e;

  // Count enable for a prescaled internal clock
  function automatic logic cpt_sel_tick(input logic [2:0] cks, input logic [1:0] icks,
                                        input logic [12:0] div, input logic pen);
    logic [12:0] m;
    m = 13'h0000;
    case (cks)
      3'h1:    m = icks[0] ? `CPT_MASK_D2 : `CPT_MASK_D8;
      3'h2:    m = icks[0] ? `CPT_MASK_D32 : `CPT_MASK_D64;
      3'h3:    m = icks[0] ? `CPT_MASK_D1024 : `CPT_MASK_D8192;
      default: m = 13'h0000;
    endcase
    // Falling edge taken half a period after the rising one
    return pen && (m != 13'h0000) && ((div & m) == (icks[1] ? (m >> 1) : m));
  endfunction

  function automatic logic cpt_apply_os(input logic pin, input logic [1:0] os);
    case (os)
      2'h1:    return 1'b0;
      2'h2:    return 1'b1;
      2'h3:    return ~pin;
      default: return pin;
    endcase
  endfunction

  function automatic logic cpt_hit(input logic [31:0] a, input logic [23:0] idx);
    return (a[31:26] == 6'h00) && (a[25:2] == idx);
  endfunction
endpackage
`default_nettype wire

// ===== hw/cpt_prescaler.sv
`default_nettype none
`include "cpt_defs.svh"
module cpt_prescaler (
  input  wire logic        aclk,    // System clock
  input  wire logic        aresetn, // Sync reset, low
  input  wire logic        halt,    // Module stop
  output logic             pen,     // Peripheral clock enable
  output logic [12:0]      div      // Prescaler count
);
  logic [7:0] acc_ff;
  logic [8:0] nxt_acc;

  // Fractional divider: 16 enables per 200 clocks, jitter of one cycle
  assign nxt_acc = {1'b0, acc_ff} + 9'(`CPT_PCLK_MHZ);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_ff <= 8'h00;
      pen    <= 1'b0;
    end else if (halt) begin
      pen <= 1'b0;
    end else if (nxt_acc >= 9'(`CPT_ACLK_MHZ)) begin
      acc_ff <= 8'(nxt_acc - 9'(`CPT_ACLK_MHZ));
      pen    <= 1'b1;
    end else begin
      acc_ff <= nxt_acc[7:0];
      pen    <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div <= 13'h0000;
    end else if (pen) begin
      div <= div + 13'h0001;
    end
  end
endmodule // cpt_prescaler
`default_nettype wire

// ===== hw/cpt_pulse_train.sv
// Behaviour
// - Channel one can count channel zero matches
// - Half-period match drives pulse pin high
// - Period match clears, drives low, advances pulses
// - Count reached clears pulse counter, raises interrupt
// - Clear select 01 clears on period match
// - Count 1 to 255 gives that many pulses
// - Period 1.0 to 128 us, 0.5 us steps
// - Stop bit 8 halts both channels
// - Clock select 100 on channel one counts period matches
// - Channel one clears on its constant match
// - Interrupt forwarded only while enable bit 6 set (count_reached_irq only; irq gates it with mask bit 0 instead)
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
`include "cpt_defs.svh"
module cpt_pulse_train
(
  input  wire logic        aclk,            // System clock
  input  wire logic        aresetn,         // Sync reset, low
  input  wire logic [31:0] s_axi_awaddr,    // Write address
  input  wire logic        s_axi_awvalid,   // Write address valid
  output logic             s_axi_awready,   // Write address ready
  input  wire logic [31:0] s_axi_wdata,     // Write data
  input  wire logic [3:0]  s_axi_wstrb,     // Write strobes
  input  wire logic        s_axi_wvalid,    // Write data valid
  output logic             s_axi_wready,    // Write data ready
  output logic [1:0]       s_axi_bresp,     // Write response
  output logic             s_axi_bvalid,    // Write response valid
  input  wire logic        s_axi_bready,    // Write response ready
  input  wire logic [31:0] s_axi_araddr,    // Read address
  input  wire logic        s_axi_arvalid,   // Read address valid
  output logic             s_axi_arready,   // Read address ready
  output logic [31:0]      s_axi_rdata,     // Read data
  output logic [1:0]       s_axi_rresp,     // Read response
  output logic             s_axi_rvalid,    // Read data valid
  input  wire logic        s_axi_rready,    // Read data ready
  output logic             pulse_out_pin,   // Pulse train
  output logic             count_reached_irq, // Channel one match A request
  output logic             irq              // Masked sticky status
);
  import cpt_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic        aw_held_ff;
  logic        w_held_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        wr_go;
  logic        ar_hs;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        wr_ok;
  cpt_byte_t   wd;
  cpt_byte_t   ctrl0_ff, ctrl1_ff, stat0_ff, stat1_ff;
  cpt_byte_t   per_const_ff, pcnt_const_ff, half_const_ff, conb1_ff;
  logic [1:0]  clk0_ff, clk1_ff;
  logic        stop_ff;
  logic [2:0]  irq_stat_ff, irq_mask_ff, irq_evt;
  logic        pen;
  logic [12:0] div;
  logic        tick0, tick1;
  cpt_byte_t   period_counter, pulse_counter;
  logic        hit_a0, hit_b0, evt_a0, evt_b0;
  logic        eq_a1, hit_a1, hit_b1;
  logic        wr_cnt0, wr_cnt1;

  function automatic logic wr_hit(input logic [23:0] idx);
    return wr_go && wstrb_ff[0] && cpt_hit(awaddr_ff, idx);
  endfunction

  // ****************************************
  // Register bus
  // ****************************************
  assign wr_go = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wd    = wdata_ff[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff    <= 1'b0;
      awaddr_ff     <= 32'h00000000;
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff    <= 1'b1;
      awaddr_ff     <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      aw_held_ff <= 1'b0;
    end else if (!aw_held_ff && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff    <= 1'b0;
      wdata_ff     <= 32'h00000000;
      wstrb_ff     <= 4'h0;
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff    <= 1'b1;
      wdata_ff     <= s_axi_wdata;
      wstrb_ff     <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      w_held_ff <= 1'b0;
    end else if (!w_held_ff && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_comb begin
    wr_ok = cpt_hit(awaddr_ff, `CPT_IDX_STOP) || cpt_hit(awaddr_ff, `CPT_IDX_IRQ_STAT) ||
            cpt_hit(awaddr_ff, `CPT_IDX_IRQ_MASK);
    for (int i = 0; i < 12; i++) begin
      if (cpt_hit(awaddr_ff, 24'(`CPT_IDX_CH0_CTRL + i))) wr_ok = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    if (cpt_hit(s_axi_araddr, `CPT_IDX_CH0_CTRL)) rd_val[7:0] = ctrl0_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_CH1_CTRL)) rd_val[7:0] = ctrl1_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_CH0_STAT)) rd_val[7:0] = stat0_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_CH1_STAT)) rd_val[7:0] = stat1_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_PER_CONST)) rd_val[7:0] = per_const_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_PCNT_CONST)) rd_val[7:0] = pcnt_const_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_HALF_CONST)) rd_val[7:0] = half_const_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_CH1_CONB)) rd_val[7:0] = conb1_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_PER_CNT)) rd_val[7:0] = period_counter;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_PULSE_CNT)) rd_val[7:0] = pulse_counter;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_CH0_CLK)) rd_val[1:0] = clk0_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_CH1_CLK)) rd_val[1:0] = clk1_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_STOP)) rd_val[`CPT_STOP_BIT] = stop_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_IRQ_STAT)) rd_val[2:0] = irq_stat_ff;
    else if (cpt_hit(s_axi_araddr, `CPT_IDX_IRQ_MASK)) rd_val[2:0] = irq_mask_ff;
    else rd_ok = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? 2'h0 : 2'h2;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_ff      <= `CPT_RST_CTRL;
      ctrl1_ff      <= `CPT_RST_CTRL;
      per_const_ff  <= `CPT_RST_CONST;
      pcnt_const_ff <= `CPT_RST_CONST;
      half_const_ff <= `CPT_RST_CONST;
      conb1_ff      <= `CPT_RST_CONST;
      clk0_ff       <= 2'h0;
      clk1_ff       <= 2'h0;
      irq_mask_ff   <= `CPT_RST_MASK;
    end else begin
      if (wr_hit(`CPT_IDX_CH0_CTRL)) ctrl0_ff <= wd;
      if (wr_hit(`CPT_IDX_CH1_CTRL)) ctrl1_ff <= wd;
      if (wr_hit(`CPT_IDX_PER_CONST)) per_const_ff <= wd;
      if (wr_hit(`CPT_IDX_PCNT_CONST)) pcnt_const_ff <= wd;
      if (wr_hit(`CPT_IDX_HALF_CONST)) half_const_ff <= wd;
      if (wr_hit(`CPT_IDX_CH1_CONB)) conb1_ff <= wd;
      if (wr_hit(`CPT_IDX_CH0_CLK)) clk0_ff <= wd[1:0];
      if (wr_hit(`CPT_IDX_CH1_CLK)) clk1_ff <= wd[1:0];
      if (wr_hit(`CPT_IDX_IRQ_MASK)) irq_mask_ff <= wd[2:0];
    end
  end

  // Stop bit sits in byte lane 1, bits 15:8
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_ff <= `CPT_RST_STOP;
    end else if (wr_go && wstrb_ff[1] && cpt_hit(awaddr_ff, `CPT_IDX_STOP)) begin
      stop_ff <= wdata_ff[`CPT_STOP_BIT];
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Writing 0 clears a flag; a match in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat0_ff <= `CPT_RST_STAT0;
    end else begin
      if (wr_hit(`CPT_IDX_CH0_STAT)) begin
        stat0_ff[3:0] <= wd[3:0];
        stat0_ff[`CPT_CMFB_BIT] <= wd[`CPT_CMFB_BIT] & stat0_ff[`CPT_CMFB_BIT] | hit_b0;
        stat0_ff[`CPT_CMFA_BIT] <= wd[`CPT_CMFA_BIT] & stat0_ff[`CPT_CMFA_BIT] | hit_a0;
      end else begin
        stat0_ff[`CPT_CMFB_BIT] <= stat0_ff[`CPT_CMFB_BIT] | hit_b0;
        stat0_ff[`CPT_CMFA_BIT] <= stat0_ff[`CPT_CMFA_BIT] | hit_a0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat1_ff <= 8'h00;
    end else if (wr_hit(`CPT_IDX_CH1_STAT)) begin
      stat1_ff[`CPT_CMFB_BIT] <= wd[`CPT_CMFB_BIT] & stat1_ff[`CPT_CMFB_BIT] | hit_b1;
      stat1_ff[`CPT_CMFA_BIT] <= wd[`CPT_CMFA_BIT] & stat1_ff[`CPT_CMFA_BIT] | hit_a1;
    end else begin
      stat1_ff[`CPT_CMFB_BIT] <= stat1_ff[`CPT_CMFB_BIT] | hit_b1;
      stat1_ff[`CPT_CMFA_BIT] <= stat1_ff[`CPT_CMFA_BIT] | hit_a1;
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  assign irq_evt = {hit_b0, hit_a0, hit_a1};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_ff <= 3'h0;
    end else if (ar_hs && cpt_hit(s_axi_araddr, `CPT_IDX_IRQ_STAT)) begin
      irq_stat_ff <= irq_evt;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_evt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq               <= 1'b0;
      count_reached_irq <= 1'b0;
    end else begin
      irq               <= |(irq_stat_ff & irq_mask_ff);
      count_reached_irq <= stat1_ff[`CPT_CMFA_BIT] && ctrl1_ff[`CPT_MATCH_A_IRQ_ENABLE_BIT];
    end
  end

  // ****************************************
  // Timer channels
  // ****************************************
  cpt_prescaler u_presc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .halt    (stop_ff),
    .pen     (pen),
    .div     (div)
  );

  // Prescaled step of Pclk/8 is 0.5 us at 16 MHz
  // Cascading both ways would loop, so channel zero treats 100 as off
  assign tick0 = !stop_ff && cpt_sel_tick(ctrl0_ff[2:0], clk0_ff, div, pen);
  assign tick1 = !stop_ff && ((ctrl1_ff[2:0] == CPT_CKS_CASCADE) ? evt_a0 :
                 cpt_sel_tick(ctrl1_ff[2:0], clk1_ff, div, pen));
  assign wr_cnt0 = wr_hit(`CPT_IDX_PER_CNT);
  assign wr_cnt1 = wr_hit(`CPT_IDX_PULSE_CNT);

  cpt_channel u_ch0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick0),
    .cclr    (ctrl0_ff[`CPT_CCLR_HI:`CPT_CCLR_LO]),
    .cora    (per_const_ff),
    .corb    (half_const_ff),
    .wr_en   (wr_cnt0),
    .wr_data (wd),
    .cnt     (period_counter),
    .eq_a    (),
    .hit_a   (hit_a0),
    .hit_b   (hit_b0),
    .evt_a   (evt_a0),
    .evt_b   (evt_b0)
  );

  cpt_channel u_ch1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick1),
    .cclr    (ctrl1_ff[`CPT_CCLR_HI:`CPT_CCLR_LO]),
    .cora    (pcnt_const_ff),
    .corb    (conb1_ff),
    .wr_en   (wr_cnt1),
    .wr_data (wd),
    .cnt     (pulse_counter),
    .eq_a    (eq_a1),
    .hit_a   (hit_a1),
    .hit_b   (hit_b1),
    .evt_a   (),
    .evt_b   ()
  );

  // Period match has priority when both constants are equal
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out_pin <= 1'b0;
    end else if (evt_a0) begin
      pulse_out_pin <= cpt_apply_os(pulse_out_pin, stat0_ff[1:0]);
    end else if (evt_b0) begin
      pulse_out_pin <= cpt_apply_os(pulse_out_pin, stat0_ff[3:2]);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_pin_rise: assert property (
    evt_b0 && !evt_a0 && stat0_ff[3:2] == 2'h2 |=> pulse_out_pin)
    else $error("pulse pin not high after half-period match");
  chk_pin_fall: assert property (
    evt_a0 && stat0_ff[1:0] == 2'h1 |=> !pulse_out_pin)
    else $error("pulse pin not low after period match");
  chk_per_clear: assert property (
    evt_a0 && ctrl0_ff[4:3] == 2'h1 && !wr_cnt0 |=> period_counter == 8'h00)
    else $error("period counter not cleared on period match");
  chk_cascade_inc: assert property (
    evt_a0 && ctrl1_ff[2:0] == 3'h4 && !eq_a1 && !wr_cnt1 && ctrl1_ff[4:3] == 2'h1
    |=> pulse_counter == $past(pulse_counter) + 8'h01)
    else $error("pulse counter did not follow period match");
  chk_pulse_clear: assert property (
    evt_a0 && ctrl1_ff[2:0] == 3'h4 && eq_a1 && ctrl1_ff[4:3] == 2'h1 && !wr_cnt1
    |=> pulse_counter == 8'h00)
    else $error("pulse counter not cleared at programmed count");
  chk_flag_set: assert property (
    $rose(eq_a1) |=> stat1_ff[6])
    else $error("match flag missing after equality");
  chk_irq_gate: assert property (
    !ctrl1_ff[6] |=> !count_reached_irq)
    else $error("interrupt forwarded while disabled");
  chk_irq_raise: assert property (
    hit_a1 && ctrl1_ff[6] && !(wr_go && cpt_hit(awaddr_ff, `CPT_IDX_CH1_CTRL))
    |-> ##2 count_reached_irq)
    else $error("count reached request not raised");
  chk_stop_halt: assert property (
    stop_ff && !wr_cnt0 |=> $stable(period_counter))
    else $error("period counter moved while stopped");
endmodule // cpt_pulse_train
`default_nettype wire

// ===== testbench/cpt_pulse_sink.sv
`default_nettype none
module cpt_pulse_sink (
  input  wire logic aclk,    // System clock
  input  wire logic aresetn, // Sync reset, low
  input  wire logic pin,     // Observed pulse line
  output var  int   edges,   // Rising edges seen
  output var  int   hi_w,    // Last high width
  output var  int   per      // Last rise to rise
);
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Passive receiver
  // ********************
  int   t_ff;
  int   rise_ff;
  logic pin_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      edges   <= 0;
      hi_w    <= 0;
      per     <= 0;
      t_ff    <= 0;
      rise_ff <= 0;
      pin_ff  <= 1'b0;
    end else begin
      t_ff   <= t_ff + 1;
      pin_ff <= pin;
      // Counts only; the line is never loaded back
      if (pin && !pin_ff) begin
        edges   <= edges + 1;
        per     <= t_ff - rise_ff;
        rise_ff <= t_ff;
      end
      if (!pin && pin_ff) begin
        hi_w <= t_ff - rise_ff;
      end
    end
  end
endmodule // cpt_pulse_sink
`default_nettype wire

// ===== testbench/testbench.sv
`default_nettype none
`include "cpt_defs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cpt_pkg::*;
  localparam int STEP = `CPT_STEP_NS * `CPT_ACLK_MHZ / 1000;
  localparam int PER_A = 3;
  localparam int HALF_B = 1;
  localparam int NPULSE = 3;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] awaddr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] araddr = '0;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic        awr, wrd, bv, arr, rv, pin, cirq, irq;
  logic [1:0]  bresp, rresp;
  logic [1:0]  wresp;
  logic [31:0] rdata;
  logic [31:0] d;
  logic [1:0]  r;
  int          edges, hi_w, per;
  int          miscompares = 0;
  int          check_count = 0;

  always #2.5 aclk = ~aclk;

  cpt_pulse_train i_cpt_pulse_train (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .pulse_out_pin(pin), .count_reached_irq(cirq), .irq(irq)
  );
  cpt_pulse_sink i_cpt_pulse_sink (
    .aclk(aclk), .aresetn(aresetn), .pin(pin), .edges(edges), .hi_w(hi_w), .per(per)
  );

  // ********************
  // Shared tasks
  // ********************
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic hang();
    miscompares++;
    end_of_test();
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [23:0] idx, input logic [31:0] v);
    int   n;
    logic a_s, w_s, b_s;
    n = 0;
    b_s = 1'b0;
    awaddr <= {6'h00, idx, 2'b00};
    wdata  <= v;
    awv    <= 1'b1;
    wv     <= 1'b1;
    bre    <= 1'b1;
    // Readies sampled mid-cycle, where they are settled
    while (b_s !== 1'b1 && n < 100) begin
      @(negedge aclk);
      a_s   = awr;
      w_s   = wrd;
      b_s   = bv;
      wresp = bresp;
      @(posedge aclk);
      n++;
      if (awv && a_s) awv <= 1'b0;
      if (wv && w_s) wv <= 1'b0;
    end
    bre <= 1'b0;
    if (b_s !== 1'b1) hang();
    @(posedge aclk);
  endtask
  task automatic rd(input logic [23:0] idx, output logic [31:0] v, output logic [1:0] rs);
    int   n;
    logic a_s, r_s;
    n = 0;
    r_s = 1'b0;
    araddr <= {6'h00, idx, 2'b00};
    arv    <= 1'b1;
    rre    <= 1'b1;
    while (r_s !== 1'b1 && n < 100) begin
      @(negedge aclk);
      a_s = arr;
      r_s = rv;
      v   = rdata;
      rs  = rresp;
      @(posedge aclk);
      n++;
      if (arv && a_s) arv <= 1'b0;
    end
    rre <= 1'b0;
    if (r_s !== 1'b1) hang();
    @(posedge aclk);
  endtask
  task automatic rd_chk(input string nm, input logic [23:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  rs;
    rd(idx, v, rs);
    chk(nm, v, exp);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic reset_values();
    rd_chk("ch0 status", `CPT_IDX_CH0_STAT, 32'h09);
    rd_chk("period const", `CPT_IDX_PER_CONST, 32'hFF);
    rd_chk("stop", `CPT_IDX_STOP, 32'h100);
    rd_chk("mask", `CPT_IDX_IRQ_MASK, 32'h0);
    rd(24'hFFFFAF, d, r);
    chk("unmapped resp", {30'h0, r}, 32'h2);
    chk("unmapped data", d, 32'h0);
    wr(24'hFFFFAF, 32'h5A);
    chk("unmapped write resp", {30'h0, wresp}, 32'h2);
    wr(`CPT_IDX_CH1_CONB, 32'h5A);
    chk("write resp", {30'h0, wresp}, 32'h0);
    rd_chk("ch1 const b", `CPT_IDX_CH1_CONB, 32'h5A);
  endtask
  task automatic run_train();
    int n;
    wr(`CPT_IDX_PER_CONST, PER_A);
    wr(`CPT_IDX_HALF_CONST, HALF_B);
    wr(`CPT_IDX_PCNT_CONST, NPULSE);
    wr(`CPT_IDX_CH1_CTRL, 32'h4C);
    wr(`CPT_IDX_PER_CNT, 32'h0);
    wr(`CPT_IDX_PULSE_CNT, 32'h0);
    wr(`CPT_IDX_CH0_CTRL, 32'h09);
    wr(`CPT_IDX_STOP, 32'h0);
    n = 0;
    while (cirq !== 1'b1 && n < 20 * STEP * (PER_A + 1)) begin
      @(posedge aclk);
      n++;
    end
    if (cirq !== 1'b1) hang();
    chk("pulses", edges, NPULSE);
    chk("period", per, (PER_A + 1) * STEP);
    chk("high width", hi_w, (PER_A - HALF_B) * STEP);
    chk("irq masked", irq, 32'h0);
    rd_chk("pulse counter", `CPT_IDX_PULSE_CNT, NPULSE);
    repeat ((PER_A + 1) * STEP) @(posedge aclk);
    rd_chk("pulse counter clear", `CPT_IDX_PULSE_CNT, 32'h0);
  endtask
  task automatic irq_path();
    wr(`CPT_IDX_IRQ_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq unmasked", irq, 32'h1);
    rd_chk("irq status", `CPT_IDX_IRQ_STAT, 32'h7);
    repeat (2) @(posedge aclk);
    chk("irq cleared", irq, 32'h0);
    chk("count irq set", cirq, 32'h1);
    wr(`CPT_IDX_CH1_CTRL, 32'h0C);
    repeat (2) @(posedge aclk);
    chk("count irq gated", cirq, 32'h0);
  endtask
  task automatic alt_clock();
    wr(`CPT_IDX_CH0_STAT, 32'h03);
    wr(`CPT_IDX_CH0_CLK, 32'h03);
    wr(`CPT_IDX_STOP, 32'h0);
    repeat (10 * (PER_A + 1) * STEP / 4) @(posedge aclk);
    chk("toggle period", per, 2 * (PER_A + 1) * STEP / 4);
    chk("toggle high", hi_w, (PER_A + 1) * STEP / 4);
  endtask
  task automatic stop_all();
    int e;
    wr(`CPT_IDX_CH0_STAT, 32'h0);
    e = edges;
    repeat (2 * (PER_A + 1) * STEP) @(posedge aclk);
    chk("no more pulses", edges, e);
    wr(`CPT_IDX_STOP, 32'h100);
    rd(`CPT_IDX_PER_CNT, d, r);
    repeat (3 * STEP) @(posedge aclk);
    rd_chk("held counter", `CPT_IDX_PER_CNT, d);
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    @(posedge aclk);
    reset_values();
    run_train();
    irq_path();
    stop_all();
    alt_clock();
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
